/* File: hw/uhbp_host_if.sv */
`timescale 1ns/1ns
interface uhbp_host_if;
	logic wr_rise;
	logic rd_fall;
	logic iack_fall;
	modport sync_mp (output wr_rise, rd_fall, iack_fall);
	modport core_mp (input wr_rise, rd_fall, iack_fall);
endinterface

/* File: hw/uhbp_pkg.sv */
package uhbp_pkg;
	// ==========================================================
	// Widths
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam int IO_W   = 8;
	localparam int IRQ_N  = 11;
	localparam int COS_N  = 6;
	localparam int DIV_W  = 16;

	// ==========================================================
	// Timing
	localparam int CLK_HZ        = 10_000_000;
	localparam int BAUD_RST_RATE = 9600;
	localparam int BAUD_R1_RATE  = 19200;
	localparam int BAUD_R2_RATE  = 38400;
	localparam int BAUD_R3_RATE  = 115200;

	// ==========================================================
	// Register offsets
	localparam logic [ADDR_W-1:0] OFS_MODE      = 7'h00;
	localparam logic [ADDR_W-1:0] OFS_STATUS    = 7'h01;
	localparam logic [ADDR_W-1:0] OFS_BAUD      = 7'h02;
	localparam logic [ADDR_W-1:0] OFS_COMMAND   = 7'h03;
	localparam logic [ADDR_W-1:0] OFS_DATA      = 7'h04;
	localparam logic [ADDR_W-1:0] OFS_ISR_LO    = 7'h05;
	localparam logic [ADDR_W-1:0] OFS_ISR_HI    = 7'h06;
	localparam logic [ADDR_W-1:0] OFS_IMR_LO    = 7'h07;
	localparam logic [ADDR_W-1:0] OFS_IMR_HI    = 7'h08;
	localparam logic [ADDR_W-1:0] OFS_OPR       = 7'h09;
	localparam logic [ADDR_W-1:0] OFS_OUT_PORT_CONFIG_REG      = 7'h0a;
	localparam logic [ADDR_W-1:0] OFS_IO_IN     = 7'h0b;
	localparam logic [ADDR_W-1:0] OFS_VECTOR    = 7'h0c;
	localparam logic [ADDR_W-1:0] OFS_CT_RELOAD = 7'h0d;
	localparam logic [ADDR_W-1:0] OFS_CT_CTRL   = 7'h0e;

	// ==========================================================
	// Field positions
	localparam int CMD_RX_EN   = 0;
	localparam int CMD_TX_EN   = 1;
	localparam int CMD_LOOP    = 2;
	localparam int CMD_CLR_ERR = 3;
	localparam int CMD_PTR_RST = 4;
	localparam int ST_RXRDY    = 0;
	localparam int ST_TXRDY    = 1;
	localparam int ST_TXEMT    = 2;
	localparam int ST_OVERRUN  = 4;
	localparam int ST_FRAME    = 6;
	localparam int STB_CS      = 0;
	localparam int STB_WR      = 1;
	localparam int STB_RD      = 2;
	localparam int STB_IACK    = 3;

	// ==========================================================
	// Reset values
	localparam logic [DATA_W-1:0] MR1_RST    = 8'h13;
	localparam logic [DATA_W-1:0] MR2_RST    = 8'h07;
	localparam logic [DATA_W-1:0] VECTOR_RST = 8'h0f;
	localparam logic [IO_W-1:0]   IO_PREV_RST = 8'hff;
	localparam logic [1:0]        BAUD_RST   = 2'h0;
	localparam logic [11:0]       SYNC_RST   = 12'hfff;

	function automatic logic [DIV_W-1:0] baud_div(input logic [1:0] code);
		int rate;
		case (code)
			2'h1: rate = BAUD_R1_RATE;
			2'h2: rate = BAUD_R2_RATE;
			2'h3: rate = BAUD_R3_RATE;
			default: rate = BAUD_RST_RATE;
		endcase
		return DIV_W'(CLK_HZ / rate);
	endfunction
endpackage

/* File: hw/uhbp_serial.sv */
`timescale 1ns/1ns
module uhbp_serial #(
	parameter int DW = 16
) (
	// Clock and reset
	input  wire logic          mclk_in,
	input  wire logic          reset_n_in,
	// Control
	input  wire logic [DW-1:0] bit_div_in,
	input  wire logic          tx_en_in,
	input  wire logic          rx_en_in,
	input  wire logic          loop_in,
	// Transmit side
	input  wire logic          tx_load_in,
	input  wire logic [7:0]    tx_data_in,
	output logic               tx_ready_out,
	output logic               serial_tx_out,
	// Receive side
	input  wire logic          serial_rx_in,
	output logic               rx_valid_out,
	output logic [7:0]         rx_data_out,
	output logic               rx_frame_err_out
);
	import uhbp_pkg::*;

	typedef struct packed {
		logic          tx_busy;
		logic [9:0]    tx_sh;
		logic [3:0]    tx_bits;
		logic [DW-1:0] tx_cnt;
		logic          tx_line;
		logic          rx_busy;
		logic [7:0]    rx_sh;
		logic [3:0]    rx_bits;
		logic [DW-1:0] rx_cnt;
		logic          rx_valid;
		logic [7:0]    rx_data;
		logic          rx_ferr;
	} uhbp_ser_t;

	uhbp_ser_t s_ff;
	uhbp_ser_t nxt_s;
	logic      int_line;
	logic      rx_line;

	// ==========================================================
	// Shifters, one bit per divider period
	always_comb begin
		nxt_s = s_ff;
		nxt_s.rx_valid = 1'b0;
		int_line = s_ff.tx_busy ? s_ff.tx_sh[0] : 1'b1;
		rx_line = loop_in ? int_line : serial_rx_in;
		if (!tx_en_in) begin
			nxt_s.tx_busy = 1'b0;
		end else if (!s_ff.tx_busy) begin
			if (tx_load_in) begin
				nxt_s.tx_busy = 1'b1;
				nxt_s.tx_sh = {1'b1, tx_data_in, 1'b0};
				nxt_s.tx_bits = 4'd10;
				nxt_s.tx_cnt = bit_div_in - 1'b1;
			end
		end else if (s_ff.tx_cnt == '0) begin
			nxt_s.tx_sh = {1'b1, s_ff.tx_sh[9:1]};
			nxt_s.tx_bits = s_ff.tx_bits - 1'b1;
			nxt_s.tx_cnt = bit_div_in - 1'b1;
			nxt_s.tx_busy = (s_ff.tx_bits != 4'd1);
		end else begin
			nxt_s.tx_cnt = s_ff.tx_cnt - 1'b1;
		end
		// Loopback keeps the pin at mark and feeds the receiver.
		nxt_s.tx_line = (loop_in || !tx_en_in) ? 1'b1
			: (nxt_s.tx_busy ? nxt_s.tx_sh[0] : 1'b1);
		if (!rx_en_in) begin
			nxt_s.rx_busy = 1'b0;
		end else if (!s_ff.rx_busy) begin
			if (!rx_line) begin
				nxt_s.rx_busy = 1'b1;
				nxt_s.rx_bits = 4'd0;
				nxt_s.rx_cnt = bit_div_in >> 1;
			end
		end else if (s_ff.rx_cnt != '0) begin
			nxt_s.rx_cnt = s_ff.rx_cnt - 1'b1;
		end else begin
			nxt_s.rx_cnt = bit_div_in - 1'b1;
			nxt_s.rx_bits = s_ff.rx_bits + 1'b1;
			if (s_ff.rx_bits == 4'd0) begin
				nxt_s.rx_busy = !rx_line;
			end else if (s_ff.rx_bits == 4'd9) begin
				nxt_s.rx_busy = 1'b0;
				nxt_s.rx_valid = 1'b1;
				nxt_s.rx_data = s_ff.rx_sh;
				nxt_s.rx_ferr = !rx_line;
			end else begin
				nxt_s.rx_sh = {rx_line, s_ff.rx_sh[7:1]};
			end
		end
	end

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			s_ff <= '{tx_line: 1'b1, default: '0};
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign tx_ready_out = tx_en_in && !s_ff.tx_busy;
	assign serial_tx_out = s_ff.tx_line;
	assign rx_valid_out = s_ff.rx_valid;
	assign rx_data_out = s_ff.rx_data;
	assign rx_frame_err_out = s_ff.rx_ferr;

	mark_when_idle_a: assert property (
		@(posedge mclk_in) disable iff (!reset_n_in)
		(!tx_en_in || loop_in) |=> serial_tx_out)
		else $error("Transmit line left mark while idle.");
endmodule // uhbp_serial

/* File: hw/uhbp_sync.sv */
`timescale 1ns/1ns
module uhbp_sync (
	// Clock and reset
	input  wire logic       mclk_in,
	input  wire logic       reset_n_in,
	// Raw strobes: cs, wr, rd, iack
	input  wire logic [3:0] strobe_n_in,
	// Synchronised view
	uhbp_host_if.sync_mp    hif_out
);
	import uhbp_pkg::*;

	typedef struct packed {
		logic [3:0] meta;
		logic [3:0] sync;
		logic [3:0] prev;
	} uhbp_sync_t;

	uhbp_sync_t s_ff;
	uhbp_sync_t nxt_s;

	// ==========================================================
	// Two-stage synchroniser with edge history
	always_comb begin
		nxt_s.meta = strobe_n_in;
		nxt_s.sync = s_ff.meta;
		nxt_s.prev = s_ff.sync;
	end

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			s_ff <= SYNC_RST;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// One pulse per edge, so each strobe commits once.
	assign hif_out.wr_rise   = s_ff.sync[STB_WR] && !s_ff.prev[STB_WR]
		&& !s_ff.prev[STB_CS];
	assign hif_out.rd_fall   = !s_ff.sync[STB_RD] && s_ff.prev[STB_RD]
		&& !s_ff.sync[STB_CS];
	assign hif_out.iack_fall = !s_ff.sync[STB_IACK]
		&& s_ff.prev[STB_IACK];

	one_write_pulse_a: assert property (
		@(posedge mclk_in) disable iff (!reset_n_in)
		hif_out.wr_rise |=> !hif_out.wr_rise)
		else $error("Write strobe gave two commits.");
endmodule // uhbp_sync

/* File: hw/uhbp_top.sv */
// What this block does
// - Strobe-style bus works only while the style select input is high.
// - Host exchanges bytes over an eight-bit three-state bus, bit 0 least.
// - Register transfers only while chip select is low; bus released while it and interrupt acknowledge are high.
// - Chip select and write strobe low load data, committed at strobe rise.
// - Chip select and read strobe low drive the register; read starts at fall.
// - A seven-bit address picks the register or port accessed.
// - Reset clears status, masks, interrupt status, out port and its config.
// - Reset turns all eight I/O pins to inputs and halts the timer.
// - Reset idles the channel at mark, points at first mode, 9600 8N1.
// - Interrupt request pulls low while any of eleven masked sources is true.
// - Interrupt acknowledge low puts the interrupt vector on the data bus.
// - Receive data arrives least significant bit first, mark high.
// - Transmit least significant bit first; mark when disabled, idle, loopback.
`timescale 1ns/1ns
module uhbp_top (
	// Clock and reset
	input  wire logic                         mclk_in,
	input  wire logic                         reset_n_in,
	input  wire logic                         host_reset_in,
	// Host bus
	input  wire logic                         bus_style_select_in,
	input  wire logic                         chip_select_n_in,
	input  wire logic                         write_strobe_n_in,
	input  wire logic                         read_strobe_n_in,
	input  wire logic [uhbp_pkg::ADDR_W-1:0]  addr_in,
	input  wire logic [uhbp_pkg::DATA_W-1:0]  data_in,
	output logic      [uhbp_pkg::DATA_W-1:0]  data_out,
	output logic                              data_oe_out,
	// Interrupt handshake
	input  wire logic                         interrupt_ack_n_in,
	output logic                              interrupt_request_n_out,
	output logic                              interrupt_request_n_oe_out,
	// Serial line
	input  wire logic                         serial_rx_in,
	output logic                              serial_tx_out,
	// General-purpose pins
	input  wire logic [uhbp_pkg::IO_W-1:0]    io_in,
	output logic      [uhbp_pkg::IO_W-1:0]    io_out,
	output logic      [uhbp_pkg::IO_W-1:0]    io_oe_out
);
	import uhbp_pkg::*;

	typedef struct packed {
		logic [DATA_W-1:0] mode1;
		logic [DATA_W-1:0] mode2;
		logic              mr_ptr;
		logic [1:0]        baud;
		logic              rx_en;
		logic              tx_en;
		logic              loop;
		logic [IRQ_N-1:0]  interrupt_mask_reg;
		logic [COS_N-1:0]  cos;
		logic              ct_evt;
		logic [DATA_W-1:0] out_port_value_reg;
		logic [DATA_W-1:0] out_port_config_reg;
		logic [DATA_W-1:0] vector;
		logic [DATA_W-1:0] ct_reload;
		logic              ct_run;
		logic [15:0]       ct_cnt;
		logic [DATA_W-1:0] rx_hold;
		logic              rx_rdy;
		logic              overrun;
		logic              frame;
		logic [IO_W-1:0]   io_prev;
		logic [DATA_W-1:0] wr_data;
		logic [ADDR_W-1:0] wr_addr;
		logic [DATA_W-1:0] rd_data;
		logic              irq;
	} uhbp_core_t;

	localparam uhbp_core_t CORE_RST = '{
		mode1: MR1_RST,
		mode2: MR2_RST,
		baud: BAUD_RST,
		vector: VECTOR_RST,
		io_prev: IO_PREV_RST,
		default: '0
	};

	uhbp_core_t        s_ff;
	uhbp_core_t        nxt_s;
	uhbp_host_if       hif ();
	logic              tx_ready;
	logic              tx_load;
	logic              rx_valid;
	logic [7:0]        rx_data;
	logic              rx_ferr;
	logic [IRQ_N-1:0]  isr_vec;
	logic [DATA_W-1:0] status_val;
	logic [DATA_W-1:0] rd_val;
	logic [IRQ_N-1:0]  isr_clr;
	logic              active;

	// ==========================================================
	// Strobe synchroniser and serial channel
	uhbp_sync u_sync (
		.mclk_in     (mclk_in),
		.reset_n_in  (reset_n_in),
		.strobe_n_in ({interrupt_ack_n_in, read_strobe_n_in,
			write_strobe_n_in, chip_select_n_in}),
		.hif_out     (hif.sync_mp)
	);

	uhbp_serial #(
		.DW (DIV_W)
	) u_serial (
		.mclk_in          (mclk_in),
		.reset_n_in       (reset_n_in),
		.bit_div_in       (baud_div(s_ff.baud)),
		.tx_en_in         (s_ff.tx_en),
		.rx_en_in         (s_ff.rx_en),
		.loop_in          (s_ff.loop),
		.tx_load_in       (tx_load),
		.tx_data_in       (s_ff.wr_data),
		.tx_ready_out     (tx_ready),
		.serial_tx_out    (serial_tx_out),
		.serial_rx_in     (serial_rx_in),
		.rx_valid_out     (rx_valid),
		.rx_data_out      (rx_data),
		.rx_frame_err_out (rx_ferr)
	);

	// ==========================================================
	// Read view of the registers
	assign active = bus_style_select_in;
	assign isr_vec = {s_ff.cos, s_ff.ct_evt, s_ff.frame, s_ff.overrun,
		s_ff.rx_rdy, tx_ready};

	always_comb begin
		status_val = '0;
		status_val[ST_RXRDY] = s_ff.rx_rdy;
		status_val[ST_TXRDY] = tx_ready;
		status_val[ST_TXEMT] = tx_ready;
		status_val[ST_OVERRUN] = s_ff.overrun;
		status_val[ST_FRAME] = s_ff.frame;
	end

	always_comb begin
		case (addr_in)
			OFS_MODE: rd_val = s_ff.mr_ptr ? s_ff.mode2 : s_ff.mode1;
			OFS_STATUS: rd_val = status_val;
			OFS_BAUD: rd_val = {6'h00, s_ff.baud};
			OFS_COMMAND: rd_val = {5'h00, s_ff.loop, s_ff.tx_en, s_ff.rx_en};
			OFS_DATA: rd_val = s_ff.rx_hold;
			OFS_ISR_LO: rd_val = isr_vec[7:0];
			OFS_ISR_HI: rd_val = {5'h00, isr_vec[IRQ_N-1:8]};
			OFS_IMR_LO: rd_val = s_ff.interrupt_mask_reg[7:0];
			OFS_IMR_HI: rd_val = {5'h00, s_ff.interrupt_mask_reg[IRQ_N-1:8]};
			OFS_OPR: rd_val = s_ff.out_port_value_reg;
			OFS_OUT_PORT_CONFIG_REG: rd_val = s_ff.out_port_config_reg;
			OFS_IO_IN: rd_val = io_in;
			OFS_VECTOR: rd_val = s_ff.vector;
			OFS_CT_RELOAD: rd_val = s_ff.ct_reload;
			OFS_CT_CTRL: rd_val = {7'h00, s_ff.ct_run};
			default: rd_val = '0;
		endcase
	end

	// ==========================================================
	// Next state
	always_comb begin
		nxt_s = s_ff;
		tx_load = 1'b0;
		isr_clr = '0;
		nxt_s.io_prev = io_in;
		// Data is captured while the strobe is low, since the bus may move
		// before the synchronised rising edge is seen.
		if (!chip_select_n_in && !write_strobe_n_in) begin
			nxt_s.wr_data = data_in;
			nxt_s.wr_addr = addr_in;
		end
		if (active && hif.wr_rise) begin
			case (s_ff.wr_addr)
				OFS_MODE: begin
					if (s_ff.mr_ptr) begin
						nxt_s.mode2 = s_ff.wr_data;
					end else begin
						nxt_s.mode1 = s_ff.wr_data;
					end
					nxt_s.mr_ptr = 1'b1;
				end
				OFS_BAUD: nxt_s.baud = s_ff.wr_data[1:0];
				OFS_COMMAND: begin
					nxt_s.rx_en = s_ff.wr_data[CMD_RX_EN];
					nxt_s.tx_en = s_ff.wr_data[CMD_TX_EN];
					nxt_s.loop = s_ff.wr_data[CMD_LOOP];
					if (s_ff.wr_data[CMD_CLR_ERR]) begin
						nxt_s.overrun = 1'b0;
						nxt_s.frame = 1'b0;
					end
					if (s_ff.wr_data[CMD_PTR_RST]) begin
						nxt_s.mr_ptr = 1'b0;
					end
				end
				OFS_DATA: tx_load = tx_ready;
				OFS_ISR_LO: isr_clr[7:4] = s_ff.wr_data[7:4];
				OFS_ISR_HI: isr_clr[IRQ_N-1:8] = s_ff.wr_data[2:0];
				OFS_IMR_LO: nxt_s.interrupt_mask_reg[7:0] = s_ff.wr_data;
				OFS_IMR_HI: nxt_s.interrupt_mask_reg[IRQ_N-1:8] = s_ff.wr_data[2:0];
				OFS_OPR: nxt_s.out_port_value_reg = s_ff.wr_data;
				OFS_OUT_PORT_CONFIG_REG: nxt_s.out_port_config_reg = s_ff.wr_data;
				OFS_VECTOR: nxt_s.vector = s_ff.wr_data;
				OFS_CT_RELOAD: nxt_s.ct_reload = s_ff.wr_data;
				OFS_CT_CTRL: begin
					nxt_s.ct_run = s_ff.wr_data[0];
					nxt_s.ct_cnt = {8'h00, s_ff.wr_data};
				end
				default: nxt_s.wr_addr = s_ff.wr_addr;
			endcase
		end
		if (active && hif.rd_fall) begin
			nxt_s.rd_data = rd_val;
			if (addr_in == OFS_DATA) begin
				nxt_s.rx_rdy = 1'b0;
			end
		end
		if (active && hif.iack_fall) begin
			nxt_s.rd_data = s_ff.vector;
		end
		nxt_s.ct_evt = s_ff.ct_evt && !isr_clr[4];
		nxt_s.cos = s_ff.cos & ~isr_clr[IRQ_N-1:5];
		// Events land after the clears so a same-cycle set survives.
		nxt_s.cos = nxt_s.cos | (io_in[COS_N-1:0] ^ s_ff.io_prev[COS_N-1:0]);
		if (s_ff.ct_run) begin
			if (s_ff.ct_cnt == '0) begin
				nxt_s.ct_cnt = {8'h00, s_ff.ct_reload};
				nxt_s.ct_evt = 1'b1;
			end else begin
				nxt_s.ct_cnt = s_ff.ct_cnt - 1'b1;
			end
		end
		if (rx_valid) begin
			if (nxt_s.rx_rdy) begin
				nxt_s.overrun = 1'b1;
			end else begin
				nxt_s.rx_hold = rx_data;
				nxt_s.rx_rdy = 1'b1;
				nxt_s.frame = nxt_s.frame || rx_ferr;
			end
		end
		nxt_s.irq = |(isr_vec & s_ff.interrupt_mask_reg);
		if (host_reset_in) begin
			nxt_s = CORE_RST;
			nxt_s.io_prev = io_in;
		end
	end

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			s_ff <= CORE_RST;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// ==========================================================
	// Pins
	assign data_out = s_ff.rd_data;
	assign data_oe_out = active && ((!chip_select_n_in && !read_strobe_n_in)
		|| !interrupt_ack_n_in);
	assign interrupt_request_n_out = 1'b0;
	assign interrupt_request_n_oe_out = s_ff.irq;
	assign io_out = s_ff.out_port_value_reg;
	assign io_oe_out = host_reset_in ? '0 : s_ff.out_port_config_reg;

	// ==========================================================
	// Checks
	style_gate_a: assert property (
		@(posedge mclk_in) disable iff (!reset_n_in)
		!bus_style_select_in |-> !data_oe_out)
		else $error("Bus driven with strobe style off.");

	bus_release_a: assert property (
		@(posedge mclk_in) disable iff (!reset_n_in)
		(chip_select_n_in && interrupt_ack_n_in) |-> !data_oe_out)
		else $error("Data bus driven while deselected.");

	write_commit_a: assert property (
		@(posedge mclk_in) disable iff (!reset_n_in)
		(active && hif.wr_rise && s_ff.wr_addr == OFS_OPR
			&& !host_reset_in) |=> s_ff.out_port_value_reg == $past(s_ff.wr_data))
		else $error("Output port write not committed.");

	read_drive_a: assert property (
		@(posedge mclk_in) disable iff (!reset_n_in)
		(active && hif.rd_fall && !hif.iack_fall && !host_reset_in
			&& addr_in == OFS_IMR_LO)
		|=> data_out == $past(s_ff.interrupt_mask_reg[7:0]))
		else $error("Read returned wrong register.");

	reset_clear_a: assert property (
		@(posedge mclk_in) disable iff (!reset_n_in)
		host_reset_in |=> (s_ff.interrupt_mask_reg == '0 && s_ff.out_port_value_reg == '0
			&& s_ff.out_port_config_reg == '0 && !s_ff.overrun && !s_ff.ct_evt))
		else $error("Reset left a register set.");

	io_input_a: assert property (
		@(posedge mclk_in) disable iff (!reset_n_in)
		host_reset_in |-> (io_oe_out == '0) ##1 !s_ff.ct_run)
		else $error("Pins or timer active in reset.");

	reset_defaults_a: assert property (
		@(posedge mclk_in) disable iff (!reset_n_in)
		host_reset_in |=> (!s_ff.mr_ptr && s_ff.baud == BAUD_RST
			&& !s_ff.tx_en && !s_ff.rx_en) ##1 serial_tx_out)
		else $error("Channel defaults wrong after reset.");

	irq_level_a: assert property (
		@(posedge mclk_in) disable iff (!reset_n_in)
		((|(isr_vec & s_ff.interrupt_mask_reg)) && !host_reset_in)
		|=> interrupt_request_n_oe_out && !interrupt_request_n_out)
		else $error("Interrupt request not asserted.");

	ack_vector_a: assert property (
		@(posedge mclk_in) disable iff (!reset_n_in)
		(active && hif.iack_fall && !host_reset_in)
		|=> data_out == $past(s_ff.vector))
		else $error("Vector not placed on bus.");
endmodule // uhbp_top

/* File: verif/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
	import uhbp_pkg::*;
	// ==========================================
	// Signals
	localparam int DIV = CLK_HZ / BAUD_R3_RATE;
	logic       mclk_in;
	logic       reset_n_in;
	logic       host_reset_in;
	logic       style;
	logic [7:0] io_in;
	wire        cs_n, wr_n, rd_n, iack_n, rx_line, d_oe, irq_n, irq_oe, tx;
	wire  [6:0] addr;
	wire  [7:0] h_data, d_out, io_out, io_oe, bus;
	int         err_total, num_checks, cyc, seed, z;
	logic [7:0] v, r;
	logic [9:0] f;
	logic [6:0] rw_a [4];
	logic [7:0] mdl [int];
	assign bus = d_oe ? d_out : h_data;
	uhbp_top uhbp_top_i (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
		.host_reset_in(host_reset_in), .bus_style_select_in(style),
		.chip_select_n_in(cs_n), .write_strobe_n_in(wr_n),
		.read_strobe_n_in(rd_n), .addr_in(addr), .data_in(bus),
		.data_out(d_out), .data_oe_out(d_oe), .interrupt_ack_n_in(iack_n),
		.interrupt_request_n_out(irq_n),
		.interrupt_request_n_oe_out(irq_oe), .serial_rx_in(rx_line),
		.serial_tx_out(tx), .io_in(io_in), .io_out(io_out),
		.io_oe_out(io_oe));
	uhbp_host_model host_i (.mclk_in(mclk_in), .cs_n_out(cs_n),
		.wr_n_out(wr_n), .rd_n_out(rd_n), .iack_n_out(iack_n),
		.addr_out(addr), .data_out(h_data), .bus_in(bus),
		.rx_line_out(rx_line));
	// ==========================================
	// Clock, watchdog and bus monitor
	initial begin
		mclk_in = 1'b0;
		forever #50 mclk_in = ~mclk_in;
	end
	always @(posedge mclk_in) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			stop_test();
		end
	end
	always @(negedge mclk_in) begin
		if ((iack_n && (cs_n || rd_n)) || !style) begin
			chk(d_oe, 8'h00, "bus driven");
		end
	end
	// ==========================================
	// Tasks
	task automatic chk(input logic [7:0] s, input logic [7:0] e,
		input string m);
		num_checks++;
		if (s !== e) begin
			err_total++;
			$display("[FAIL] %0t %s: saw %h want %h", $time, m, s, e);
		end
	endtask
	task automatic wrm(input logic [6:0] a, input logic [7:0] d);
		mdl[a] = d;
		host_i.wr(a, d, 1'b0, 3);
	endtask
	task automatic rchk(input logic [6:0] a);
		logic [7:0] e;
		e = mdl.exists(a) ? mdl[a] : 8'h00;
		host_i.rd(a, 1'b0, r);
		chk(r, e, "read back");
	endtask
	task automatic get_frame();
		for (int k = 0; k < 200 && tx !== 1'b0; k++) begin
			@(negedge mclk_in);
		end
		repeat (DIV / 2) @(negedge mclk_in);
		for (int i = 0; i < 10; i++) begin
			f[i] = tx;
			repeat (DIV) @(negedge mclk_in);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// ==========================================
	// Main sequence
	initial begin
		seed = 6;
		err_total = 0;
		num_checks = 0;
		cyc = 0;
		reset_n_in = 1'b0;
		host_reset_in = 1'b0;
		style = 1'b1;
		io_in = 8'hff;
		rw_a = '{OFS_OPR, OFS_OUT_PORT_CONFIG_REG, OFS_VECTOR, OFS_IMR_LO};
		mdl[OFS_VECTOR] = VECTOR_RST;
		repeat (20) @(posedge mclk_in);
		reset_n_in <= 1'b1;
		repeat (3) @(posedge mclk_in);
		for (int p = 0; p < 2; p++) begin
			chk(tx, 8'h01, "tx at mark");
			chk(io_oe, 8'h00, "io pins as inputs");
			host_i.rd(OFS_MODE, 1'b0, r);
			chk(r, MR1_RST, "first mode");
			host_i.wr(OFS_MODE, MR1_RST, 1'b0, 3);
			host_i.rd(OFS_MODE, 1'b0, r);
			chk(r, MR2_RST, "second mode");
			rchk(OFS_BAUD);
			rchk(OFS_IMR_HI);
			rchk(OFS_CT_CTRL);
			for (int i = 0; i < 4; i++) rchk(rw_a[i]);
			if (p == 1) break;
			for (int n = 0; n < 8; n++) begin
				wrm(rw_a[n % 4], 8'($random(seed)));
				rchk(rw_a[n % 4]);
			end
			chk(io_out, mdl[OFS_OPR], "out port");
			wrm(OFS_OUT_PORT_CONFIG_REG, 8'hff);
			chk(io_oe, 8'hff, "out config");
			host_i.wr(7'h40, 8'h5a, 1'b0, 3);
			rchk(7'h40);
			host_i.wr(OFS_OPR, ~mdl[OFS_OPR], 1'b1, 3);
			host_i.rd(OFS_OPR, 1'b1, r);
			style <= 1'b0;
			host_i.wr(OFS_OPR, ~mdl[OFS_OPR], 1'b0, 3);
			host_i.rd(OFS_OPR, 1'b0, r);
			style <= 1'b1;
			repeat (3) @(posedge mclk_in);
			chk(io_out, mdl[OFS_OPR], "ignored write");
			v = 8'($random(seed));
			wrm(OFS_COMMAND, 8'h10);
			host_i.wr(OFS_MODE, v, 1'b0, 12);
			host_i.rd(OFS_MODE, 1'b0, r);
			chk(r, MR2_RST, "one access per strobe");
			wrm(OFS_COMMAND, 8'h10);
			host_i.rd(OFS_MODE, 1'b0, r);
			chk(r, v, "mode written");
			wrm(OFS_IMR_LO, 8'h20);
			wrm(OFS_IMR_HI, 8'h00);
			wrm(OFS_ISR_LO, 8'hf0);
			wrm(OFS_ISR_HI, 8'h07);
			chk(irq_oe, 8'h00, "no request");
			io_in <= 8'hfe;
			repeat (8) @(posedge mclk_in);
			chk(irq_oe, 8'h01, "request pulled");
			chk(irq_n, 8'h00, "request level");
			host_i.rd(OFS_ISR_LO, 1'b0, r);
			chk(r, 8'h20, "change flag");
			host_i.ack(r);
			chk(r, mdl[OFS_VECTOR], "vector");
			io_in <= 8'hfc;
			wrm(OFS_ISR_LO, 8'h20);
			repeat (4) @(posedge mclk_in);
			chk(irq_oe, 8'h00, "masked source");
			wrm(OFS_BAUD, 8'h03);
			wrm(OFS_COMMAND, 8'h02);
			chk(tx, 8'h01, "idle mark");
			v = 8'($random(seed));
			wrm(OFS_DATA, v);
			get_frame();
			chk(f[8:1], v, "tx bits");
			chk({f[9], f[0]}, 8'h02, "tx framing");
			wrm(OFS_COMMAND, 8'h07);
			wrm(OFS_DATA, ~v);
			z = 0;
			for (int k = 0; k < 12 * DIV; k++) begin
				@(negedge mclk_in);
				if (tx !== 1'b1) z++;
			end
			chk(8'(z > 0), 8'h00, "mark in loopback");
			rchk(OFS_DATA);
			wrm(OFS_COMMAND, 8'h01);
			v = 8'($random(seed));
			host_i.ser(v, DIV);
			mdl[OFS_DATA] = v;
			rchk(OFS_DATA);
			wrm(OFS_OPR, 8'($random(seed)));
			wrm(OFS_OUT_PORT_CONFIG_REG, 8'hff);
			wrm(OFS_CT_CTRL, 8'h01);
			rchk(OFS_CT_CTRL);
			@(posedge mclk_in);
			host_reset_in <= 1'b1;
			@(negedge mclk_in);
			chk(io_oe, 8'h00, "reset floats pins");
			@(posedge mclk_in);
			host_reset_in <= 1'b0;
			repeat (4) @(posedge mclk_in);
			mdl.delete();
			mdl[OFS_VECTOR] = VECTOR_RST;
			chk(io_out, 8'h00, "out port cleared");
		end
		stop_test();
	end
endmodule // tb_top

/* File: verif/uhbp_host_model.sv */
`timescale 1ns/1ns
// ==========================================
// Host processor model
module uhbp_host_model (
	// Clock
	input  wire logic       mclk_in,
	// Host bus drive
	output logic            cs_n_out,
	output logic            wr_n_out,
	output logic            rd_n_out,
	output logic            iack_n_out,
	output logic [6:0]      addr_out,
	output logic [7:0]      data_out,
	// Resolved data bus
	input  wire logic [7:0] bus_in,
	// Serial line into the device
	output logic            rx_line_out
);
	initial begin
		cs_n_out = 1'b1;
		wr_n_out = 1'b1;
		rd_n_out = 1'b1;
		iack_n_out = 1'b1;
		addr_out = 7'h00;
		data_out = 8'h00;
		rx_line_out = 1'b1;
	end
	// ==========================================
	// Bus cycles
	// Released lines show the inverse of the last value, so late capture
	// in the device picks up garbage rather than a lucky copy.
	task automatic wr(input logic [6:0] a, input logic [7:0] d,
		input logic cs, input int n);
		@(posedge mclk_in);
		cs_n_out <= cs;
		wr_n_out <= 1'b0;
		addr_out <= a;
		data_out <= d;
		repeat (n) @(posedge mclk_in);
		cs_n_out <= 1'b1;
		wr_n_out <= 1'b1;
		addr_out <= ~a;
		data_out <= ~d;
		repeat (5) @(posedge mclk_in);
	endtask
	task automatic rd(input logic [6:0] a, input logic cs,
		output logic [7:0] d);
		@(posedge mclk_in);
		cs_n_out <= cs;
		rd_n_out <= 1'b0;
		addr_out <= a;
		repeat (5) @(posedge mclk_in);
		d = bus_in;
		cs_n_out <= 1'b1;
		rd_n_out <= 1'b1;
		addr_out <= ~a;
		repeat (2) @(posedge mclk_in);
	endtask
	task automatic ack(output logic [7:0] d);
		@(posedge mclk_in);
		iack_n_out <= 1'b0;
		repeat (5) @(posedge mclk_in);
		d = bus_in;
		iack_n_out <= 1'b1;
		repeat (2) @(posedge mclk_in);
	endtask
	task automatic ser(input logic [7:0] d, input int div);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rx_line_out <= f[i];
			repeat (div) @(posedge mclk_in);
		end
	endtask
endmodule // uhbp_host_model
